// file: core/qdsr_dac_end.sv
// Register and command logic of the quad DAC, a slave on the two-wire link.
// Operation
// - Writes: write address, pointer, then data
// - Pointer: don't-care, two zeros, channel selects
// - Multiple selects get identical word
// - Word gathered as two bytes, 16 bits
// - Word: range, drive, clear, power-down, code
// - Range bit picks single or double span
// - Drive bit enables reference buffering
// - Clear bit zero zeroes all registers
// - Power-down bit zero powers down channels
// - Pointer resets zero; empty select reads default
// - Several selected read zeros plus clear/power-down
// - Acknowledge address and pointer; two data bytes
// - Read: pointer, repeated start, read address
// - Acknowledged second byte repeats the word
// - Bare read address uses last pointer
// - Input registers load only on completion
// - Load pin low makes DAC registers follow
// - DAC register updates only when input written
// - Readback uses the write word layout
// - Address is 00011 plus two straps
// - Reset zeroes registers, unbuffered, single span
// - Load low updates after final eighth clock
// - Power-down keeps registers and accepts writes
`timescale 1ns/1ns
module qdsr_dac_end (
  input wire logic i_core_clk,
  input wire logic i_reset,
  qdsr_link_if.dev link,
  input wire logic i_addr_strap_low,
  input wire logic i_addr_strap_high,
  input wire logic i_load_outputs_n,
  output logic [qdsr_pkg::NUM_CH-1:0][qdsr_pkg::CODE_W-1:0] o_dac_code,
  output logic [qdsr_pkg::NUM_CH-1:0] o_out_range_2x,
  output logic [qdsr_pkg::NUM_CH-1:0] o_ref_buffered,
  output logic o_power_down_n
);
  typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_MACK} qdsr_dev_state_t;

  qdsr_dev_state_t state;
  logic [4:0] sync_a;
  logic [4:0] sync_b;
  logic [1:0] line_prev;
  logic scl_s;
  logic sda_s;
  logic load_n_s;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic [2:0] bit_cnt;
  logic [7:0] shreg;
  logic [7:0] rx_byte;
  logic byte_done;
  logic addr_match;
  logic in_addr;
  logic rd_mode;
  logic [1:0] byte_idx;
  logic ack_ok;
  logic ack_on;
  logic tx_lo;
  logic [15:0] tx_sh;
  logic [7:0] pointer;
  logic [7:0] word_hi;
  logic [15:0] word;
  logic clr_bit;
  logic commit;
  logic [qdsr_pkg::NUM_CH-1:0] sel;
  logic [15:0] readback;
  logic [qdsr_pkg::CODE_W-1:0] in_code [qdsr_pkg::NUM_CH];
  logic in_gain [qdsr_pkg::NUM_CH];
  logic in_buf [qdsr_pkg::NUM_CH];
  logic dirty [qdsr_pkg::NUM_CH];

  // ==========================================================================
  // Pin synchronisers and line events
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      sync_a <= qdsr_pkg::DEV_SYNC_RESET;
      sync_b <= qdsr_pkg::DEV_SYNC_RESET;
      line_prev <= 2'h3;
    end else begin
      sync_a <= {i_load_outputs_n, i_addr_strap_high, i_addr_strap_low, link.sda, link.scl};
      sync_b <= sync_a;
      line_prev <= sync_b[1:0];
    end
  end

  assign scl_s = sync_b[0];
  assign sda_s = sync_b[1];
  assign load_n_s = sync_b[4];
  assign scl_rise = scl_s && !line_prev[0];
  assign scl_fall = !scl_s && line_prev[0];
  assign bus_start = scl_s && line_prev[0] && !sda_s && line_prev[1];
  assign bus_stop = scl_s && line_prev[0] && sda_s && !line_prev[1];
  assign rx_byte = {shreg[6:0], sda_s};
  assign byte_done = (state == ST_RX) && scl_rise && (bit_cnt == 3'h7);
  assign addr_match = rx_byte[7:1] == {qdsr_pkg::SLAVE_ADDR_HI, sync_b[3], sync_b[2]};

  // ==========================================================================
  // Link state machine and data line drive
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      state <= ST_IDLE;
      bit_cnt <= 3'h0;
      shreg <= 8'h00;
      in_addr <= 1'b1;
      rd_mode <= 1'b0;
      byte_idx <= 2'h0;
      ack_ok <= 1'b0;
      ack_on <= 1'b0;
      tx_lo <= 1'b0;
      tx_sh <= 16'h0000;
      link.dev_sda_oe <= 1'b0;
    end else if (bus_stop) begin
      state <= ST_IDLE;
      link.dev_sda_oe <= 1'b0;
    end else if (bus_start) begin
      state <= ST_RX;
      bit_cnt <= 3'h0;
      in_addr <= 1'b1;
      byte_idx <= 2'h0;
      link.dev_sda_oe <= 1'b0;
    end else begin
      case (state)
        ST_RX: begin
          if (scl_rise) begin
            shreg <= rx_byte;
            bit_cnt <= bit_cnt + 3'h1;
            if (bit_cnt == 3'h7) begin
              state <= ST_ACK;
              ack_on <= 1'b0;
              if (in_addr) begin
                ack_ok <= addr_match;
                rd_mode <= rx_byte[0];
              end else begin
                ack_ok <= (byte_idx != 2'h3);
              end
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            if (!ack_on) begin
              if (ack_ok) begin
                link.dev_sda_oe <= 1'b1;
                ack_on <= 1'b1;
              end else begin
                state <= ST_IDLE;
              end
            end else if (in_addr && rd_mode) begin
              // A read address always answers with data at once. 
              state <= ST_TX;
              in_addr <= 1'b0;
              tx_lo <= 1'b0;
              bit_cnt <= 3'h0;
              tx_sh <= readback;
              link.dev_sda_oe <= !readback[15];
            end else begin
              state <= ST_RX;
              bit_cnt <= 3'h0;
              link.dev_sda_oe <= 1'b0;
              if (in_addr) begin
                in_addr <= 1'b0;
              end else begin
                byte_idx <= byte_idx + 2'h1;
              end
            end
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            if (bit_cnt == 3'h7) begin
              state <= ST_MACK;
              link.dev_sda_oe <= 1'b0;
            end else begin
              link.dev_sda_oe <= !tx_sh[14];
              tx_sh <= {tx_sh[14:0], 1'b0};
              bit_cnt <= bit_cnt + 3'h1;
            end
          end
        end
        ST_MACK: begin
          if (scl_rise && sda_s) begin
            state <= ST_IDLE;
          end else if (scl_fall) begin
            state <= ST_TX;
            bit_cnt <= 3'h0;
            if (tx_lo) begin
              tx_sh <= readback;
              link.dev_sda_oe <= !readback[15];
              tx_lo <= 1'b0;
            end else begin
              link.dev_sda_oe <= !tx_sh[14];
              tx_sh <= {tx_sh[14:0], 1'b0};
              tx_lo <= 1'b1;
            end
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_core_clk) begin
    link.dev_sda_o <= 1'b0;
  end

  // ==========================================================================
  // Pointer, assembled word and global control bits
  // Reserved pointer bits set means nothing is selected, so later data is dropped.
  assign sel = (pointer[qdsr_pkg::PTR_RSV_HI:qdsr_pkg::PTR_RSV_LO] == 2'h0) ?
      pointer[qdsr_pkg::NUM_CH-1:0] : 4'h0;
  assign word = {word_hi, rx_byte};
  // A pointer with reserved bits set also blocks the global clear and power-down bits.
  assign commit = byte_done && !in_addr && (byte_idx == 2'h2) &&
      (pointer[qdsr_pkg::PTR_RSV_HI:qdsr_pkg::PTR_RSV_LO] == 2'h0);

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      pointer <= qdsr_pkg::PTR_RESET;
      word_hi <= 8'h00;
      clr_bit <= qdsr_pkg::CLR_RESET;
      o_power_down_n <= qdsr_pkg::PD_RESET;
    end else if (byte_done && !in_addr) begin
      if (byte_idx == 2'h0) begin
        pointer <= rx_byte;
      end
      if (byte_idx == 2'h1) begin
        word_hi <= rx_byte;
      end
      if (commit) begin
        clr_bit <= word[qdsr_pkg::W_CLR];
        o_power_down_n <= word[qdsr_pkg::W_PD];
      end
    end
  end

  // ==========================================================================
  // Per-channel input and DAC registers
  for (genvar ch = 0; ch < qdsr_pkg::NUM_CH; ch++) begin : g_chan
    always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
        in_code[ch] <= '0;
        in_gain[ch] <= 1'b0;
        in_buf[ch] <= 1'b0;
        dirty[ch] <= 1'b0;
        o_dac_code[ch] <= '0;
        o_out_range_2x[ch] <= 1'b0;
        o_ref_buffered[ch] <= 1'b0;
      end else if (commit && !word[qdsr_pkg::W_CLR]) begin
        in_code[ch] <= '0;
        in_gain[ch] <= 1'b0;
        in_buf[ch] <= 1'b0;
        dirty[ch] <= 1'b0;
        o_dac_code[ch] <= '0;
        o_out_range_2x[ch] <= 1'b0;
        o_ref_buffered[ch] <= 1'b0;
      end else if (commit && sel[ch]) begin
        // A write in the same cycle as a transfer wins; the transfer follows next cycle.
        in_code[ch] <= word[qdsr_pkg::CODE_W-1:0];
        in_gain[ch] <= word[qdsr_pkg::W_GAIN];
        in_buf[ch] <= word[qdsr_pkg::W_BUF];
        dirty[ch] <= 1'b1;
      end else if (!load_n_s && dirty[ch]) begin
        o_dac_code[ch] <= in_code[ch];
        o_out_range_2x[ch] <= in_gain[ch];
        o_ref_buffered[ch] <= in_buf[ch];
        dirty[ch] <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Readback word
  always_comb begin
    readback = qdsr_pkg::RB_DEFAULT;
    if ((sel != 4'h0) && !$onehot(sel)) begin
      readback = {2'h0, clr_bit, o_power_down_n, 12'h000};
    end
    for (int ch = 0; ch < qdsr_pkg::NUM_CH; ch++) begin
      if (sel[ch] && $onehot(sel)) begin
        readback = {in_gain[ch], in_buf[ch], clr_bit, o_power_down_n, in_code[ch]};
      end
    end
  end
endmodule : qdsr_dac_end

// file: pkg/qdsr_pkg.sv
// Shared constants for the quad DAC two-wire register interface and its bus master.
package qdsr_pkg;
  // ==========================================================================
  // Channel word and addressing
  localparam int NUM_CH = 4;
  localparam int CODE_W = 12;
  localparam logic [4:0] SLAVE_ADDR_HI = 5'h03;
  localparam int W_GAIN = 15;
  localparam int W_BUF = 14;
  localparam int W_CLR = 13;
  localparam int W_PD = 12;
  localparam int PTR_RSV_HI = 5;
  localparam int PTR_RSV_LO = 4;
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam logic [15:0] RB_DEFAULT = 16'h3000;
  localparam logic CLR_RESET = 1'b1;
  localparam logic PD_RESET = 1'b1;
  // Idle levels of {load_n, strap_high, strap_low, sda, scl} in the synchroniser.
  localparam logic [4:0] DEV_SYNC_RESET = 5'h13;

  // ==========================================================================
  // Timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int SCL_PERIOD_NS = 400;
  localparam int SCL_QUARTER_RAW = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
  localparam int SCL_QUARTER_CYC = (SCL_QUARTER_RAW < 1) ? 1 : SCL_QUARTER_RAW;

  // ==========================================================================
  // Bus master register map (byte addresses)
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_PTR = 5'h04;
  localparam logic [4:0] REG_WDATA = 5'h08;
  localparam logic [4:0] REG_RDATA = 5'h0c;
  localparam logic [4:0] REG_STATUS = 5'h10;
  localparam int CTRL_OP_LO = 0;
  localparam int CTRL_STRAP_LO = 4;
  localparam int CTRL_GO = 8;
  localparam int STAT_BUSY = 0;
  localparam int STAT_NACK = 1;
  localparam logic [1:0] OP_WRITE = 2'h0;
  localparam logic [1:0] OP_READ = 2'h1;
  localparam logic [1:0] OP_CURRENT = 2'h2;
endpackage : qdsr_pkg

// file: pkg/qdsr_link_if.sv
// Two-wire link between the bus master and the quad DAC register end.
`timescale 1ns/1ns
interface qdsr_link_if;
  logic scl;
  logic sda;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;

  // Open-drain data line with a pull-up: any enabled low driver wins.
  assign sda = !((host_sda_oe && !host_sda_o) || (dev_sda_oe && !dev_sda_o));

  modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe);
  modport host (output scl, input sda, output host_sda_o, output host_sda_oe);
endinterface : qdsr_link_if

// file: core/qdsr_bus_master.sv
// Two-wire bus master that runs DAC transactions ordered over Avalon-MM registers.
`timescale 1ns/1ns
module qdsr_bus_master (
  input wire logic i_core_clk,
  input wire logic i_reset,
  qdsr_link_if.host link,
  input wire logic [4:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest
);
  typedef enum logic [3:0] {
    RL_START, RL_AW, RL_PTR, RL_WHI, RL_WLO, RL_AR, RL_RHI, RL_RLO, RL_STOP
  } qdsr_role_t;

  logic [1:0] op;
  logic [1:0] strap;
  logic [7:0] ptr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic busy;
  logic nack;
  logic abort;
  logic [2:0] step;
  logic [1:0] quarter;
  logic [3:0] bit_n;
  logic [7:0] rx_sh;
  logic [7:0] tx_byte;
  logic [$clog2(qdsr_pkg::SCL_QUARTER_CYC+1)-1:0] div;
  logic tick;
  logic [1:0] sda_sync;
  logic wr_go;
  logic acc;
  qdsr_role_t role;

  function automatic qdsr_role_t role_of(input logic [1:0] o, input logic [2:0] s);
    qdsr_role_t r;
    r = RL_STOP;
    case ({o, s})
      {qdsr_pkg::OP_WRITE, 3'h0}, {qdsr_pkg::OP_READ, 3'h0}: r = RL_START;
      {qdsr_pkg::OP_READ, 3'h3}, {qdsr_pkg::OP_CURRENT, 3'h0}: r = RL_START;
      {qdsr_pkg::OP_WRITE, 3'h1}, {qdsr_pkg::OP_READ, 3'h1}: r = RL_AW;
      {qdsr_pkg::OP_WRITE, 3'h2}, {qdsr_pkg::OP_READ, 3'h2}: r = RL_PTR;
      {qdsr_pkg::OP_WRITE, 3'h3}: r = RL_WHI;
      {qdsr_pkg::OP_WRITE, 3'h4}: r = RL_WLO;
      {qdsr_pkg::OP_READ, 3'h4}, {qdsr_pkg::OP_CURRENT, 3'h1}: r = RL_AR;
      {qdsr_pkg::OP_READ, 3'h5}, {qdsr_pkg::OP_CURRENT, 3'h2}: r = RL_RHI;
      {qdsr_pkg::OP_READ, 3'h6}, {qdsr_pkg::OP_CURRENT, 3'h3}: r = RL_RLO;
      default: r = RL_STOP;
    endcase
    return r;
  endfunction : role_of

  // ==========================================================================
  // Avalon-MM slave: every access is answered one cycle after it is raised.
  assign acc = (i_avs_read || i_avs_write) && !o_avs_waitrequest;
  assign wr_go = acc && i_avs_write && (i_avs_address == qdsr_pkg::REG_CTRL) &&
      i_avs_writedata[qdsr_pkg::CTRL_GO] && !busy;

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      o_avs_waitrequest <= 1'b1;
    end else begin
      o_avs_waitrequest <= !((i_avs_read || i_avs_write) && o_avs_waitrequest);
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      o_avs_readdata <= 32'h0000_0000;
    end else if (i_avs_read && o_avs_waitrequest) begin
      case (i_avs_address)
        qdsr_pkg::REG_CTRL: o_avs_readdata <= {26'h000_0000, strap, 2'h0, op};
        qdsr_pkg::REG_PTR: o_avs_readdata <= {24'h00_0000, ptr};
        qdsr_pkg::REG_WDATA: o_avs_readdata <= {16'h0000, wdata};
        qdsr_pkg::REG_RDATA: o_avs_readdata <= {16'h0000, rdata};
        qdsr_pkg::REG_STATUS: o_avs_readdata <= {30'h0000_0000, nack, busy};
        default: o_avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  // Settings are refused while a transaction runs, so it sees a stable order.
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      op <= qdsr_pkg::OP_WRITE;
      strap <= 2'h0;
      ptr <= qdsr_pkg::PTR_RESET;
      wdata <= 16'h0000;
    end else if (acc && i_avs_write && !busy) begin
      case (i_avs_address)
        qdsr_pkg::REG_CTRL: begin
          op <= i_avs_writedata[qdsr_pkg::CTRL_OP_LO +: 2];
          strap <= i_avs_writedata[qdsr_pkg::CTRL_STRAP_LO +: 2];
        end
        qdsr_pkg::REG_PTR: ptr <= i_avs_writedata[7:0];
        qdsr_pkg::REG_WDATA: wdata <= i_avs_writedata[15:0];
        default: ;
      endcase
    end
  end

  // ==========================================================================
  // Quarter-period divider and data line synchroniser
  assign tick = (div == ($bits(div))'(qdsr_pkg::SCL_QUARTER_CYC - 1));

  always_ff @(posedge i_core_clk) begin
    if (i_reset || !busy || tick) begin
      div <= '0;
    end else begin
      div <= div + 1'b1;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      sda_sync <= 2'h3;
    end else begin
      sda_sync <= {sda_sync[0], link.sda};
    end
  end

  // ==========================================================================
  // Transaction engine: four quarters per bit, nine bits per byte.
  assign role = abort ? RL_STOP : role_of(op, step);

  always_comb begin
    case (role)
      RL_AW: tx_byte = {qdsr_pkg::SLAVE_ADDR_HI, strap, 1'b0};
      RL_AR: tx_byte = {qdsr_pkg::SLAVE_ADDR_HI, strap, 1'b1};
      RL_PTR: tx_byte = ptr;
      RL_WHI: tx_byte = wdata[15:8];
      RL_WLO: tx_byte = wdata[7:0];
      default: tx_byte = 8'hff;
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      busy <= 1'b0;
      nack <= 1'b0;
      abort <= 1'b0;
      step <= 3'h0;
      quarter <= 2'h0;
      bit_n <= 4'h0;
      rx_sh <= 8'h00;
      rdata <= 16'h0000;
      link.scl <= 1'b1;
      link.host_sda_oe <= 1'b0;
    end else if (wr_go) begin
      busy <= 1'b1;
      nack <= 1'b0;
      abort <= 1'b0;
      step <= 3'h0;
      quarter <= 2'h0;
      bit_n <= 4'h0;
    end else if (busy && tick) begin
      quarter <= quarter + 2'h1;
      if (role == RL_START) begin
        case (quarter)
          2'h0: link.host_sda_oe <= 1'b0;
          2'h1: link.scl <= 1'b1;
          2'h2: link.host_sda_oe <= 1'b1;
          default: begin
            link.scl <= 1'b0;
            step <= step + 3'h1;
          end
        endcase
      end else if (role == RL_STOP) begin
        case (quarter)
          2'h0: link.host_sda_oe <= 1'b1;
          2'h1: link.scl <= 1'b1;
          2'h2: link.host_sda_oe <= 1'b0;
          default: busy <= 1'b0;
        endcase
      end else begin
        case (quarter)
          2'h0: begin
            if (bit_n != 4'h8) begin
              link.host_sda_oe <= (role == RL_RHI || role == RL_RLO) ? 1'b0 :
                  !tx_byte[3'h7 - bit_n[2:0]];
            end else begin
              // The last byte of a read is refused so the slave lets go for the stop.
              link.host_sda_oe <= (role == RL_RHI);
            end
          end
          2'h1: link.scl <= 1'b1;
          2'h2: begin
            if (bit_n != 4'h8) begin
              rx_sh <= {rx_sh[6:0], sda_sync[1]};
            end else if (sda_sync[1] && role != RL_RHI && role != RL_RLO) begin
              nack <= 1'b1;
              abort <= 1'b1;
            end
          end
          default: begin
            link.scl <= 1'b0;
            if (bit_n == 4'h8) begin
              bit_n <= 4'h0;
              step <= step + 3'h1;
              if (role == RL_RHI) begin
                rdata[15:8] <= rx_sh;
              end
              if (role == RL_RLO) begin
                rdata[7:0] <= rx_sh;
              end
            end else begin
              bit_n <= bit_n + 4'h1;
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    link.host_sda_o <= 1'b0;
  end
endmodule : qdsr_bus_master

// file: test/qdsr_link_chk.sv
// Checker for the two-wire link between the bus master and the DAC end.
`timescale 1ns/1ns
module qdsr_link_chk (
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic scl,
  input wire logic sda,
  input wire logic host_sda_o,
  input wire logic host_sda_oe,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_reset);
  // ==========================================================================
  // Assertions
  dev_open_drain_a: assert property (dev_sda_oe |-> !dev_sda_o)
    else $error("device data driver drives high");
  host_open_drain_a: assert property (host_sda_oe |-> !host_sda_o)
    else $error("master data driver drives high");
  ack_pulls_low_a: assert property (dev_sda_oe |-> !sda)
    else $error("device drive does not pull the data line low");
  dev_sets_low_a: assert property ($rose(dev_sda_oe) |-> !scl)
    else $error("device starts driving while clock high");
  dev_frees_low_a: assert property ($fell(dev_sda_oe) |-> !scl)
    else $error("device releases data while clock high");
  dev_holds_high_a: assert property (scl && $past(scl) |-> $stable(dev_sda_oe))
    else $error("device data changes during clock high");
  scl_high_len_a: assert property ($rose(scl) |-> scl [*4])
    else $error("clock high phase too short");
  scl_low_len_a: assert property ($fell(scl) |-> !scl [*4])
    else $error("clock low phase too short");
  // ==========================================================================
  // Coverage
  start_seen_c: cover property (scl && $fell(sda));
  stop_seen_c: cover property (scl && $rose(sda));
  ack_seen_c: cover property ($rose(dev_sda_oe));
endmodule : qdsr_link_chk

// file: test/testbench.sv
// Self-checking bench: Avalon orders to the master, checks at the DAC end.
`timescale 1ns/1ns
module testbench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [4:0] av_addr = 5'h00;
  logic av_rd = 1'b0;
  logic av_wr = 1'b0;
  logic [31:0] av_wdata = 32'h0000_0000;
  logic [31:0] av_rdata;
  logic av_wait;
  logic strap_low = 1'b0;
  logic strap_high = 1'b1;
  logic load_outputs_n = 1'b0;
  logic [qdsr_pkg::NUM_CH-1:0][qdsr_pkg::CODE_W-1:0] code;
  logic [qdsr_pkg::NUM_CH-1:0] rng;
  logic [qdsr_pkg::NUM_CH-1:0] bufd;
  logic pd_n;
  logic [31:0] st;
  logic [31:0] rd;
  int error_cnt = 0;
  int checks = 0;

  always #25 clk = ~clk;

  qdsr_link_if i_qdsr_link_if ();
  qdsr_bus_master i_qdsr_bus_master (.i_core_clk(clk), .i_reset(rst), .link(i_qdsr_link_if),
    .i_avs_address(av_addr), .i_avs_read(av_rd), .i_avs_write(av_wr),
    .i_avs_writedata(av_wdata), .o_avs_readdata(av_rdata), .o_avs_waitrequest(av_wait));
  qdsr_dac_end i_qdsr_dac_end (.i_core_clk(clk), .i_reset(rst), .link(i_qdsr_link_if),
    .i_addr_strap_low(strap_low), .i_addr_strap_high(strap_high),
    .i_load_outputs_n(load_outputs_n), .o_dac_code(code), .o_out_range_2x(rng),
    .o_ref_buffered(bufd), .o_power_down_n(pd_n));
  qdsr_link_chk i_qdsr_link_chk (.i_core_clk(clk), .i_reset(rst),
    .scl(i_qdsr_link_if.scl), .sda(i_qdsr_link_if.sda),
    .host_sda_o(i_qdsr_link_if.host_sda_o), .host_sda_oe(i_qdsr_link_if.host_sda_oe),
    .dev_sda_o(i_qdsr_link_if.dev_sda_o), .dev_sda_oe(i_qdsr_link_if.dev_sda_oe));

  task complete_run;
    $display("checks=%0d error_cnt=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : complete_run

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // ==========================================================================
  // Avalon access: request held until waitrequest is sampled low.
  // Only the watchdog ends a wait that never gets its answer.
  task avs(input logic wr, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    av_addr <= a;
    av_wdata <= d;
    av_wr <= wr;
    av_rd <= !wr;
    do begin
      @(posedge clk);
    end while (av_wait !== 1'b0);
    q = av_rdata;
    av_wr <= 1'b0;
    av_rd <= 1'b0;
  endtask : avs

  task run_op(input logic [1:0] op, input logic [1:0] strap, input logic [7:0] ptr,
              input logic [15:0] word);
    avs(1'b1, qdsr_pkg::REG_PTR, {24'h00_0000, ptr}, rd);
    avs(1'b1, qdsr_pkg::REG_WDATA, {16'h0000, word}, rd);
    avs(1'b1, qdsr_pkg::REG_CTRL, {23'h00_0000, 1'b1, 2'h0, strap, 2'h0, op}, rd);
    st = 32'h0000_0001;
    while (st[qdsr_pkg::STAT_BUSY] !== 1'b0) begin
      avs(1'b0, qdsr_pkg::REG_STATUS, 32'h0000_0000, st);
    end
  endtask : run_op

  task read_chk(input logic [1:0] op, input logic [7:0] ptr, input logic [31:0] exp);
    run_op(op, 2'h2, ptr, 16'h0000);
    avs(1'b0, qdsr_pkg::REG_RDATA, 32'h0000_0000, rd);
    chk(rd, exp);
  endtask : read_chk

  // ==========================================================================
  // Watchdog: the whole sequence needs well under 20000 cycles.
  initial begin
    #(20000 * 50);
    error_cnt++;
    complete_run();
  end

  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    chk(32'({pd_n, bufd, rng}), 32'h0000_0100);
    chk(32'(|code), 32'h0000_0000);
    avs(1'b1, 5'h14, 32'hffff_ffff, rd);
    avs(1'b0, 5'h14, 32'h0000_0000, rd);
    chk(rd, 32'h0000_0000);
    read_chk(qdsr_pkg::OP_CURRENT, 8'h00, 32'(qdsr_pkg::RB_DEFAULT));
    run_op(qdsr_pkg::OP_WRITE, 2'h1, 8'h0f, 16'hf123);
    chk(32'(st[qdsr_pkg::STAT_NACK]), 32'h0000_0001);
    chk(32'(|code), 32'h0000_0000);
    run_op(qdsr_pkg::OP_WRITE, 2'h2, 8'h01, 16'hfabc);
    chk(32'(st[qdsr_pkg::STAT_NACK]), 32'h0000_0000);
    chk(32'(code[0]), 32'h0000_0abc);
    run_op(qdsr_pkg::OP_WRITE, 2'h2, 8'hce, 16'h3123);
    chk(32'({code[3], code[1]}), 32'h0012_3123);
    chk(32'({code[0], bufd, rng}), 32'h000a_bc11);
    read_chk(qdsr_pkg::OP_READ, 8'h01, 32'h0000_fabc);
    read_chk(qdsr_pkg::OP_READ, 8'h06, 32'h0000_3000);
    read_chk(qdsr_pkg::OP_READ, 8'h02, 32'h0000_3123);
    read_chk(qdsr_pkg::OP_CURRENT, 8'h00, 32'h0000_3123);
    @(posedge clk);
    load_outputs_n <= 1'b1;
    run_op(qdsr_pkg::OP_WRITE, 2'h2, 8'h01, 16'h3555);
    chk(32'(code[0]), 32'h0000_0abc);
    load_outputs_n <= 1'b0;
    repeat (8) @(posedge clk);
    chk(32'({code[1], code[0]}), 32'h0012_3555);
    run_op(qdsr_pkg::OP_WRITE, 2'h2, 8'h11, 16'h0fff);
    chk(32'({st[qdsr_pkg::STAT_NACK], pd_n, code[0]}), 32'h0000_1555);
    run_op(qdsr_pkg::OP_WRITE, 2'h2, 8'h04, 16'h2777);
    chk(32'({pd_n, code[2]}), 32'h0000_0777);
    run_op(qdsr_pkg::OP_WRITE, 2'h2, 8'h04, 16'h3777);
    chk(32'(pd_n), 32'h0000_0001);
    run_op(qdsr_pkg::OP_WRITE, 2'h2, 8'h01, 16'h1000);
    chk(32'(|code), 32'h0000_0000);
    read_chk(qdsr_pkg::OP_READ, 8'h02, 32'h0000_1000);
    complete_run();
  end
endmodule : testbench
